/* File: design/rtg_cfg.svh */
// Register offsets, reset values and timing counts of the timing and
// curve register bank. Assumes a 250 MHz core clock.
`ifndef RTG_CFG_SVH
`define RTG_CFG_SVH
`define RTG_A_REV 8'h1e
`define RTG_A_DP 8'h1f
`define RTG_A_RGBF 8'h20
`define RTG_A_PINF 8'h21
`define RTG_A_RED 8'h27
`define RTG_A_GRN 8'h28
`define RTG_A_BLU 8'h29
`define RTG_A_P1 8'h2a
`define RTG_A_P2 8'h2b
`define RTG_A_P3 8'h2c
`define RTG_A_ID 8'h70
`define RTG_A_VER 8'h71
`define RTG_RST_REV 8'h19
`define RTG_RST_ZERO 8'h00
`define RTG_CURVE_MSB 2
`define RTG_WIN_UNIT_MS 10
`define RTG_DP_HOLDOFF_MS 100
`define RTG_CLK_HZ 250000000
`define RTG_MS_NS 1000000
`define RTG_CLK_NS 4
`define RTG_MS_CYCLES (`RTG_MS_NS / `RTG_CLK_NS)
`define RTG_CARRIER_HZ 31250
`define RTG_PWM_CYCLES (`RTG_CLK_HZ / `RTG_CARRIER_HZ)
`endif

/* File: design/rtg_pkg.sv */
// Types shared by the timing and curve register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package rtg_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [2:0] curve_t;
	typedef logic [2:0][7:0] level_trio_t;
	typedef enum logic [1:0] {
		DP_IDLE = 2'b00,
		DP_WAIT = 2'b01,
		DP_HOLD = 2'b10
	} dp_state_e;
endpackage

/* File: design/carrier_if.sv */
// Shared PWM carrier count passed from the bank to its PWM lanes.
// Assumes one core clock domain.
`timescale 1ns/10ps
`default_nettype none
interface carrier_if;
	logic [12:0] count;
	modport source(output count);
	modport sink(input count);
endinterface
`default_nettype wire

/* File: design/gamma_pwm.sv */
// One gamma-corrected PWM lane on the shared carrier.
// Assumes the carrier count runs 0 to period-1 on the core clock.
`timescale 1ns/10ps
`default_nettype none
`include "rtg_cfg.svh"
module gamma_pwm (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	carrier_if.sink car,
	input wire logic [7:0] i_level,
	input wire logic [2:0] i_curve,
	input wire logic i_enable,
	output logic o_pwm
);
	localparam logic [12:0] PERIOD = 13'(`RTG_PWM_CYCLES);
	logic [7:0] duty;
	wire logic [15:0] sq = 16'(i_level) * 16'(i_level);
	wire logic [7:0] sq8 = 8'((17'(sq) + 17'(i_level)) >> 8);
	wire logic [15:0] cu = 16'(sq8) * 16'(i_level);
	wire logic [7:0] cu8 = 8'((17'(cu) + 17'(i_level)) >> 8);
	wire logic [7:0] corrected;
	wire logic [20:0] lhs = 21'(car.count) * 21'd255;
	wire logic [20:0] rhs = 21'(duty) * 21'(PERIOD);

	// Blend of two powers in sixteenths; an approximation of the
	// fractional curves that avoids a table per curve.
	function automatic logic [7:0] mix(input logic [7:0] a,
		input logic [7:0] b, input logic [4:0] wa);
		logic [12:0] s;
		s = 13'(a) * 13'(wa) + 13'(b) * 13'(5'd16 - wa);
		return s[11:4];
	endfunction

	assign corrected = (i_curve == 3'b000) ? i_level :
		(i_curve == 3'b001) ? i_level :
		(i_curve == 3'b010) ? mix(i_level, sq8, 5'd3) :
		(i_curve == 3'b011) ? sq8 :
		(i_curve == 3'b100) ? mix(sq8, cu8, 5'd13) :
		(i_curve == 3'b101) ? mix(sq8, cu8, 5'd10) :
		(i_curve == 3'b110) ? mix(sq8, cu8, 5'd6) :
		mix(sq8, cu8, 5'd3);

	// Duty only changes at the carrier wrap so no period is torn.
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			duty <= 8'h00;
			o_pwm <= 1'b0;
		end else begin
			if (car.count == 13'h0000)
				duty <= corrected;
			o_pwm <= i_enable && (lhs < rhs);
		end
	end

	AST_LANE_OFF: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b) !i_enable |=> !o_pwm)
		else $error("pwm lane drives while disabled");
	AST_FULL_ON: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b) (i_enable && duty == 8'hff) |=> o_pwm)
		else $error("full duty not held high");
endmodule
`default_nettype wire

/* File: design/rotary_timing_gamma_regs.sv */
// Timing and curve register bank of a rotary knob board, with the
// logic that these registers steer.
// Assumes a byte register port driven by the serial bus front end and
// knob event pulses that are synchronous to the core clock.
//
// Overview of operation
// - Reversal window register counts in steps of ten milliseconds.
// - Opposite-direction steps inside the reversal window are dropped.
// - Reversal window register resets to 25, meaning 250 ms.
// - Double-press window register counts in steps of ten milliseconds.
// - A zero double-press window turns double-press detection off.
// - Each knob LED fade step lasts the programmed number of ms.
// - Without an RGB knob fitted the LED fade-step setting is ignored.
// - Pin fade-step time acts only on pins set to PWM.
// - Each LED curve selector shapes only its own colour channel.
// - Codes 001 to 111 pick gamma 1, 1.8, 2.0, 2.2, 2.4, 2.6, 2.8.
// - Code 000 sends the intensity straight to the PWM output.
// - Pin curve selectors use the same codes, only in PWM mode.
// - An 8-bit read-only board identity register; writes do nothing.
// - An 8-bit read-only release level register; writes are ignored.
// - Gamma path PWM outputs run on a 31.25 kHz carrier.
// - After a double press, presses are ignored for an extra delay.
`timescale 1ns/10ps
`default_nettype none
`include "rtg_cfg.svh"
module rotary_timing_gamma_regs #(
	parameter int TICK_CYCLES = `RTG_MS_CYCLES,
	parameter logic [7:0] BOARD_ID = 8'h5a, // Arbitrary value.
	parameter logic [7:0] RELEASE = 8'h01 // Arbitrary value.
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	input wire logic i_step,
	input wire logic i_step_dir,
	output logic o_step,
	output logic o_step_dir,
	input wire logic i_press,
	output logic o_double_press,
	input wire logic i_rgb_fitted,
	output logic o_rgb_fade_step,
	input wire logic [2:0] i_pin_pwm_mode,
	output logic o_pin_fade_step,
	input wire rtg_pkg::level_trio_t i_led_level,
	input wire rtg_pkg::level_trio_t i_pin_level,
	output logic [2:0] o_led_pwm,
	output logic [2:0] o_pin_pwm
);
	localparam logic [11:0] UNIT = 12'(`RTG_WIN_UNIT_MS);
	localparam logic [11:0] HOLDOFF = 12'(`RTG_DP_HOLDOFF_MS);
	localparam logic [12:0] PERIOD = 13'(`RTG_PWM_CYCLES);

	////////////////////////////////////////////////////////////////////
	// Register file.
	rtg_pkg::byte_t rev_win, dp_win, rgb_fade, pin_fade;
	rtg_pkg::curve_t led_curve [3];
	rtg_pkg::curve_t pin_curve [3];
	wire logic wr_rev = i_reg_wr && i_reg_addr == `RTG_A_REV;
	wire logic wr_dp = i_reg_wr && i_reg_addr == `RTG_A_DP;
	wire logic wr_rgbf = i_reg_wr && i_reg_addr == `RTG_A_RGBF;
	wire logic wr_pinf = i_reg_wr && i_reg_addr == `RTG_A_PINF;
	wire logic [2:0] wr_led = {i_reg_wr && i_reg_addr == `RTG_A_BLU,
		i_reg_wr && i_reg_addr == `RTG_A_GRN,
		i_reg_wr && i_reg_addr == `RTG_A_RED};
	wire logic [2:0] wr_pin = {i_reg_wr && i_reg_addr == `RTG_A_P3,
		i_reg_wr && i_reg_addr == `RTG_A_P2,
		i_reg_wr && i_reg_addr == `RTG_A_P1};
	wire rtg_pkg::curve_t new_curve = i_reg_wdata[`RTG_CURVE_MSB:0];

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			rev_win <= `RTG_RST_REV;
			dp_win <= `RTG_RST_ZERO;
			rgb_fade <= `RTG_RST_ZERO;
			pin_fade <= `RTG_RST_ZERO;
		end else begin
			if (wr_rev)
				rev_win <= i_reg_wdata;
			if (wr_dp)
				dp_win <= i_reg_wdata;
			if (wr_rgbf)
				rgb_fade <= i_reg_wdata;
			if (wr_pinf)
				pin_fade <= i_reg_wdata;
		end
	end

	// Only the low three bits are stored, so the rest read as zero.
	always_ff @(posedge i_core_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (!i_rst_b) begin
				led_curve[i] <= 3'b000;
				pin_curve[i] <= 3'b000;
			end else begin
				if (wr_led[i])
					led_curve[i] <= new_curve;
				if (wr_pin[i])
					pin_curve[i] <= new_curve;
			end
		end
	end

	// Identity and release level have no storage, so writes vanish.
	wire logic [7:0] rd_mux =
		(i_reg_addr == `RTG_A_REV) ? rev_win :
		(i_reg_addr == `RTG_A_DP) ? dp_win :
		(i_reg_addr == `RTG_A_RGBF) ? rgb_fade :
		(i_reg_addr == `RTG_A_PINF) ? pin_fade :
		(i_reg_addr == `RTG_A_RED) ? {5'h00, led_curve[0]} :
		(i_reg_addr == `RTG_A_GRN) ? {5'h00, led_curve[1]} :
		(i_reg_addr == `RTG_A_BLU) ? {5'h00, led_curve[2]} :
		(i_reg_addr == `RTG_A_P1) ? {5'h00, pin_curve[0]} :
		(i_reg_addr == `RTG_A_P2) ? {5'h00, pin_curve[1]} :
		(i_reg_addr == `RTG_A_P3) ? {5'h00, pin_curve[2]} :
		(i_reg_addr == `RTG_A_ID) ? BOARD_ID :
		(i_reg_addr == `RTG_A_VER) ? RELEASE : 8'h00;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b)
			o_reg_rdata <= 8'h00;
		else if (i_reg_rd)
			o_reg_rdata <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////
	// Millisecond time base.
	logic [17:0] tick_cnt;
	logic ms_tick;
	wire logic tick_wrap = tick_cnt == 18'(TICK_CYCLES - 1);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			tick_cnt <= 18'h00000;
			ms_tick <= 1'b0;
		end else begin
			tick_cnt <= tick_wrap ? 18'h00000 : tick_cnt + 18'h00001;
			ms_tick <= tick_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reversal suppression.
	logic [11:0] rev_left;
	logic last_dir;
	wire logic opposite = i_step_dir != last_dir && rev_left != 12'h000;
	wire logic accept = i_step && !opposite;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			rev_left <= 12'h000;
			last_dir <= 1'b0;
			o_step <= 1'b0;
			o_step_dir <= 1'b0;
		end else begin
			o_step <= accept;
			if (accept) begin
				o_step_dir <= i_step_dir;
				last_dir <= i_step_dir;
				rev_left <= 12'(rev_win) * UNIT;
			end else if (ms_tick && rev_left != 12'h000) begin
				rev_left <= rev_left - 12'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Double press detection.
	rtg_pkg::dp_state_e dp_state, next_dp_state;
	logic [11:0] dp_left;
	wire logic dp_expired = dp_left == 12'h000;
	wire logic dp_hit = dp_state == rtg_pkg::DP_WAIT && i_press;

	always_comb begin
		next_dp_state = dp_state;
		unique case (dp_state)
			rtg_pkg::DP_IDLE:
				if (i_press && dp_win != 8'h00)
					next_dp_state = rtg_pkg::DP_WAIT;
			rtg_pkg::DP_WAIT:
				if (i_press)
					next_dp_state = rtg_pkg::DP_HOLD;
				else if (dp_expired)
					next_dp_state = rtg_pkg::DP_IDLE;
			rtg_pkg::DP_HOLD:
				if (dp_expired)
					next_dp_state = rtg_pkg::DP_IDLE;
			default:
				next_dp_state = rtg_pkg::DP_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			dp_state <= rtg_pkg::DP_IDLE;
			dp_left <= 12'h000;
			o_double_press <= 1'b0;
		end else begin
			dp_state <= next_dp_state;
			o_double_press <= dp_hit;
			if (dp_state == rtg_pkg::DP_IDLE)
				dp_left <= 12'(dp_win) * UNIT;
			else if (dp_hit)
				dp_left <= HOLDOFF;
			else if (ms_tick && !dp_expired)
				dp_left <= dp_left - 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Fade step pacing; a zero step time means no fade stepping.
	logic [7:0] rgb_cnt, pin_cnt;
	wire logic rgb_run = i_rgb_fitted && rgb_fade != 8'h00;
	wire logic pin_run = |i_pin_pwm_mode && pin_fade != 8'h00;
	wire logic rgb_due = rgb_cnt >= rgb_fade - 8'h01;
	wire logic pin_due = pin_cnt >= pin_fade - 8'h01;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b || !rgb_run) begin
			rgb_cnt <= 8'h00;
			o_rgb_fade_step <= 1'b0;
		end else begin
			o_rgb_fade_step <= ms_tick && rgb_due;
			if (ms_tick)
				rgb_cnt <= rgb_due ? 8'h00 : rgb_cnt + 8'h01;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b || !pin_run) begin
			pin_cnt <= 8'h00;
			o_pin_fade_step <= 1'b0;
		end else begin
			o_pin_fade_step <= ms_tick && pin_due;
			if (ms_tick)
				pin_cnt <= pin_due ? 8'h00 : pin_cnt + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// PWM carrier and gamma lanes.
	carrier_if car ();
	logic [12:0] car_cnt;
	assign car.count = car_cnt;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b)
			car_cnt <= 13'h0000;
		else if (car_cnt == PERIOD - 13'h0001)
			car_cnt <= 13'h0000;
		else
			car_cnt <= car_cnt + 13'h0001;
	end

	for (genvar i = 0; i < 3; i++) begin : g_lane
		gamma_pwm u_led (
			.i_core_clk(i_core_clk),
			.i_rst_b(i_rst_b),
			.car(car),
			.i_level(i_led_level[i]),
			.i_curve(led_curve[i]),
			.i_enable(i_rgb_fitted),
			.o_pwm(o_led_pwm[i])
		);
		gamma_pwm u_pin (
			.i_core_clk(i_core_clk),
			.i_rst_b(i_rst_b),
			.car(car),
			.i_level(i_pin_level[i]),
			.i_curve(pin_curve[i]),
			.i_enable(i_pin_pwm_mode[i]),
			.o_pwm(o_pin_pwm[i])
		);
	end

	////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_reverse;
		i_step && opposite;
	endsequence
	sequence s_double;
		dp_hit ##1 o_double_press;
	endsequence

	AST_REV_RESET: assert property (@(posedge i_core_clk)
		!i_rst_b |=> rev_win == 8'h19)
		else $error("reversal window reset value wrong");
	AST_REV_DROP: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b) s_reverse |=> !o_step)
		else $error("reversed step passed inside window");
	AST_REV_LOAD: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		accept |=> rev_left == 12'($past(rev_win)) * 12'd10)
		else $error("reversal window not loaded in tens of ms");
	AST_DP_OFF: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		(dp_win == 8'h00 && dp_state == rtg_pkg::DP_IDLE) |=>
		dp_state == rtg_pkg::DP_IDLE)
		else $error("double press armed with zero window");
	AST_DP_HOLD: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		s_double |-> dp_state == rtg_pkg::DP_HOLD && !dp_expired)
		else $error("no hold-off after double press");
	AST_ID_RO: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		(i_reg_rd && i_reg_addr == `RTG_A_ID) |=> o_reg_rdata == BOARD_ID)
		else $error("identity register read wrong");
	AST_CURVE_HI: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b)
		(i_reg_rd && i_reg_addr >= `RTG_A_RED &&
		i_reg_addr <= `RTG_A_P3) |=> o_reg_rdata[7:3] == 5'h00)
		else $error("curve selector upper bits not zero");
	AST_RGB_IDLE: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b) !i_rgb_fitted |=> !o_rgb_fade_step)
		else $error("fade step without RGB knob");
	AST_TICK_GAP: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_b) ms_tick |=> !ms_tick [*4])
		else $error("millisecond ticks too close");
endmodule
`default_nettype wire

/* File: verif/reg_host.sv */
// Byte register master standing in for the serial bus front end.
// Assumes the bank takes a strobe at a rising edge of the core clock.
`timescale 1ns/10ps
`default_nettype none
module reg_host (
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 8'h00;
		o_rd = 1'b0;
	end
	// Released lines show the inverse value so stale data cannot match.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		#1;
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(posedge i_core_clk);
		#1;
		o_wr = 1'b0;
		o_wdata = ~d;
		o_addr = ~a;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		#1;
		o_addr = a;
		o_rd = 1'b1;
		@(posedge i_core_clk);
		#1;
		o_rd = 1'b0;
		o_addr = ~a;
		d = i_rdata;
	endtask
endmodule
`default_nettype wire

/* File: verif/rotary_timing_gamma_regs_bench.sv */
// Self-checking bench of the timing and curve register bank.
// Assumes a shortened millisecond tick of 20 core clock cycles.
`timescale 1ns/10ps
`default_nettype none
`include "rtg_cfg.svh"
module rotary_timing_gamma_regs_bench;
	localparam int TICK = 20;
	logic clk = 1'b0, rst_b = 1'b0, wr, rd, step = 1'b0, dir = 1'b0;
	logic press = 1'b0, fitted = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic [2:0] pwm_mode = 3'b000, led_pwm, pin_pwm;
	logic o_step, o_dir, o_dp, o_rgbf, o_pinf;
	rtg_pkg::level_trio_t lvl = {3{8'h80}};
	logic [7:0] mon;
	int n_fail = 0, cmp_count = 0;
	int cnt [8];
	int g [8];
	assign mon = {pin_pwm, led_pwm, o_pinf, o_rgbf};
	always #2 clk = ~clk;
	reg_host i_host (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wr(wr), .o_wdata(wdata), .o_rd(rd));
	rotary_timing_gamma_regs #(.TICK_CYCLES(TICK)) i_dut (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .i_step(step), .i_step_dir(dir),
		.o_step(o_step), .o_step_dir(o_dir), .i_press(press),
		.o_double_press(o_dp), .i_rgb_fitted(fitted),
		.o_rgb_fade_step(o_rgbf), .i_pin_pwm_mode(pwm_mode),
		.o_pin_fade_step(o_pinf), .i_led_level(lvl), .i_pin_level(lvl),
		.o_led_pwm(led_pwm), .o_pin_pwm(pin_pwm));
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s seen %0h expected %0h",
				$time, msg, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic measure(input int n);
		int b;
		for (b = 0; b < 8; b++) cnt[b] = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			for (b = 0; b < 8; b++) if (mon[b] === 1'b1) cnt[b]++;
		end
	endtask
	task automatic do_step(input logic d, input logic exp);
		@(posedge clk);
		#1;
		step = 1'b1;
		dir = d;
		@(posedge clk);
		#1;
		step = 1'b0;
		check(o_step, exp, "step pulse");
		if (exp) check(o_dir, d, "step direction");
	endtask
	task automatic do_press(input logic exp);
		@(posedge clk);
		#1;
		press = 1'b1;
		@(posedge clk);
		#1;
		press = 1'b0;
		check(o_dp, exp, "double press pulse");
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic test_regs;
		logic [7:0] a [12] = '{8'h1e, 8'h1f, 8'h20, 8'h21, 8'h27, 8'h28,
			8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h70, 8'h71};
		logic [7:0] d;
		int i;
		for (i = 0; i < 12; i++) begin
			i_host.read_reg(a[i], d);
			if (i == 0) check(d, 8'h19, "reset window");
			else if (i < 10) check(d, 8'h00, "reset value");
			i_host.write_reg(a[i], 8'hff);
			i_host.read_reg(a[i], d);
			if (i < 4) check(d, 8'hff, "rw byte");
			else if (i < 10) check(d, 8'h07, "curve bits");
			else if (i == 10) check(d, 8'h5a, "identity");
			else check(d, 8'h01, "release");
		end
		i_host.read_reg(8'h40, d);
		check(d, 8'h00, "unmapped read");
		$display("register test done");
	endtask
	// Window of 1 unit is 10 ticks, 200 cycles.
	task automatic test_steps;
		i_host.write_reg(8'h1e, 8'h01);
		do_step(1'b1, 1'b1);
		do_step(1'b0, 1'b0);
		do_step(1'b1, 1'b1);
		repeat (150) @(posedge clk);
		do_step(1'b0, 1'b0);
		repeat (80) @(posedge clk);
		do_step(1'b0, 1'b1);
		$display("step test done");
	endtask
	task automatic test_press;
		i_host.write_reg(8'h1f, 8'h00);
		do_press(1'b0);
		do_press(1'b0);
		i_host.write_reg(8'h1f, 8'h02);
		do_press(1'b0);
		repeat (10) @(posedge clk);
		do_press(1'b1);
		do_press(1'b0);
		do_press(1'b0);
		repeat (2100) @(posedge clk);
		do_press(1'b0);
		repeat (450) @(posedge clk);
		do_press(1'b0);
		do_press(1'b1);
		$display("double press test done");
	endtask
	task automatic test_fade;
		i_host.write_reg(8'h20, 8'h03);
		i_host.write_reg(8'h21, 8'h02);
		fitted = 1'b1;
		measure(600);
		check(cnt[0], 10, "led fade steps");
		check(cnt[1], 0, "pin fade off");
		check(cnt[5] + cnt[6] + cnt[7], 0, "pin pwm off");
		fitted = 1'b0;
		pwm_mode = 3'b010;
		measure(600);
		check(cnt[0], 0, "led fade unfitted");
		check(cnt[1], 15, "pin fade steps");
		$display("fade test done");
	endtask
	task automatic pwm_round(input logic [2:0] c [6]);
		int i;
		for (i = 0; i < 6; i++)
			i_host.write_reg(8'(8'h27 + i), {5'h00, c[i]});
		measure(8000);
		measure(8000);
		for (i = 0; i < 6; i++) g[c[i]] = cnt[i + 2];
	endtask
	// Linear duty at level 128 is the count of c with c*255 < 128*8000.
	task automatic test_pwm;
		int lin, k;
		lin = (128 * 8000 + 254) / 255;
		fitted = 1'b1;
		pwm_mode = 3'b111;
		pwm_round('{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5});
		check(g[0], lin, "curve off");
		pwm_round('{3'd6, 3'd7, 3'd0, 3'd0, 3'd1, 3'd0});
		check(g[0], lin, "curve off beside curved");
		check(cnt[4], lin, "blue linear beside curved");
		check(g[1], lin, "gamma one");
		for (k = 2; k < 8; k++)
			check(g[k] < g[k - 1], 1'b1, "curve order");
		// Full intensity must hold the LED lanes high for the whole period.
		pwm_mode = 3'b000;
		lvl = {3{8'hff}};
		measure(8000);
		measure(8000);
		check(cnt[2] + cnt[3] + cnt[4], 24000, "full intensity");
		check(cnt[5] + cnt[6] + cnt[7], 0, "pin pwm mode off");
		$display("pwm test done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		#1;
		check({o_step, o_dir, o_dp, o_rgbf, o_pinf, led_pwm, pin_pwm}, 0,
			"reset");
		check(rdata, 8'h00, "reset read data");
		rst_b = 1'b1;
		test_regs();
		test_steps();
		test_press();
		test_fade();
		test_pwm();
		give_verdict();
	end
endmodule
`default_nettype wire
